/* verilog/evr_router.sv */
/*
 * evr_router: event link router, nineteen sources to six receiving operations.
 * assumes: all event inputs are one-cycle pulses on clk_in from on-chip logic,
 * software keeps each destination to one source and writes only while idle.
 */
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module evr_router
    import evr_pkg::*;
#(
    parameter bit HAS_KEY_RETURN = 1'b1   // key-return source present
)(
    input  wire logic        clk_in,                     // system clock
    input  wire logic        rst_in,                     // sync reset, high
    // ahb-lite slave
    input  wire logic        hsel_in,                    // slave select
    input  wire logic [31:0] haddr_in,                   // byte address
    input  wire logic [1:0]  htrans_in,                  // transfer type
    input  wire logic        hwrite_in,                  // write
    input  wire logic [2:0]  hsize_in,                   // size
    input  wire logic [31:0] hwdata_in,                  // write data
    input  wire logic        hready_in,                  // bus ready
    output logic      [31:0] hrdata_out,                 // read data
    output logic             hreadyout_out,              // always ready
    output logic             hresp_out,                  // always okay
    // event sources
    input  wire logic [5:0]  ext_edge_event_in,          // external pins 0-5
    input  wire logic        key_return_event_in,        // key return
    input  wire logic        capture_timer0_event_a_in,  // timer 0 match a
    input  wire logic        capture_timer0_event_b_in,  // timer 0 match b
    input  wire logic        capture_timer1_event_a_in,  // timer 1 match a
    input  wire logic        capture_timer1_event_b_in,  // timer 1 match b
    input  wire logic        capture_timer1_under_in,    // timer 1 underflow
    input  wire logic        interval_timer0_event_in,   // interval underflow
    input  wire logic [3:0]  timer_array_event_in,       // channels 0-3 end
    input  wire logic        comparator0_event_in,       // comparator 0
    input  wire logic        comparator1_event_in,       // comparator 1
    // receiving operations
    output logic             adc_start_out,              // conversion trigger
    output logic             timer_array_ch0_in_out,     // channel 0 input
    output logic             timer_array_ch1_in_out,     // channel 1 input
    output logic             interval_timer0_count_out,  // count source
    output logic             capture_timer0_d_input_out, // d capture, timer 0
    output logic             capture_timer0_cutoff_out,  // cutoff, timer 0
    output logic             capture_timer1_d_input_out, // d capture, timer 1
    output logic             capture_timer1_cutoff_out   // cutoff, timer 1
);

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic                 rd_en;
    logic [EVR_IDX_W-1:0] rd_idx;
    logic                 wr_en;
    logic [EVR_IDX_W-1:0] wr_idx;

    evr_ahb_slave u_slave (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .hsel_in    (hsel_in),
        .haddr_in   (haddr_in),
        .htrans_in  (htrans_in),
        .hwrite_in  (hwrite_in),
        .hsize_in   (hsize_in),
        .hready_in  (hready_in),
        .rd_en_out  (rd_en),
        .rd_idx_out (rd_idx),
        .wr_en_out  (wr_en),
        .wr_idx_out (wr_idx)
    );

    ////////////////////////////////////////////////////////////////////////////
    // route select registers

    evr_sel_t route_sel      [EVR_NUM_SRC];
    evr_sel_t next_route_sel [EVR_NUM_SRC];

    // only the low three bits are stored, upper bits stay zero
    always_comb
    begin
        for (int s = 0; s < EVR_NUM_SRC; s++)
        begin
            next_route_sel[s] = route_sel[s];
            if (wr_en && wr_idx == EVR_IDX_W'(s))
            begin
                next_route_sel[s] = hwdata_in[EVR_SEL_W-1:0];
            end
            if (s == EVR_SRC_KEY && !HAS_KEY_RETURN)
            begin
                next_route_sel[s] = EVR_SEL_OFF;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        for (int s = 0; s < EVR_NUM_SRC; s++)
        begin
            route_sel[s] <= rst_in ? EVR_SEL_RESET[EVR_SEL_W-1:0]
                                   : next_route_sel[s];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status: shared destinations and prohibited codes, for software checks

    logic [7:0] status;
    logic [7:0] next_status;

    // built from next selects so a read right after a write sees it
    always_comb
    begin
        logic [EVR_NUM_DEST-1:0] seen;
        seen        = '0;
        next_status = 8'h00;
        for (int s = 0; s < EVR_NUM_SRC; s++)
        begin
            next_status[EVR_NUM_DEST-1:0] = next_status[EVR_NUM_DEST-1:0]
                                          | (seen & evr_dest_onehot(next_route_sel[s]));
            seen = seen | evr_dest_onehot(next_route_sel[s]);
            if (next_route_sel[s] == EVR_SEL_BAD)
            begin
                next_status[6] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        status <= rst_in ? 8'h00 : next_status;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, registered at the address phase edge

    logic [31:0] next_hrdata;

    // reads take next values so back-to-back write then read is coherent
    always_comb
    begin
        next_hrdata = 32'h0000_0000;
        if (rd_en && rd_idx == EVR_LOC_STATUS)
        begin
            next_hrdata = {24'h00_0000, next_status};
        end
        else if (rd_en && rd_idx < EVR_IDX_W'(EVR_NUM_SRC))
        begin
            next_hrdata = {29'h0000_0000, next_route_sel[rd_idx]};
        end
    end

    always_ff @(posedge clk_in)
    begin
        hrdata_out    <= rst_in ? 32'h0000_0000 : next_hrdata;
        hreadyout_out <= 1'b1;  // zero wait states, never stalls
        hresp_out     <= 1'b0;  // every access answers okay
    end

    ////////////////////////////////////////////////////////////////////////////
    // source map and routing matrix

    logic [EVR_NUM_SRC-1:0]  src_event;
    logic [EVR_NUM_DEST-1:0] dest_hit;

    // fixed source numbering; no interrupt mask gates any of it
    always_comb
    begin
        src_event[5:0]   = ext_edge_event_in;
        src_event[6]     = key_return_event_in && HAS_KEY_RETURN;
        src_event[7]     = capture_timer0_event_a_in;
        src_event[8]     = capture_timer0_event_b_in;
        src_event[9]     = capture_timer1_event_a_in;
        src_event[10]    = capture_timer1_event_b_in;
        src_event[11]    = capture_timer1_under_in;
        src_event[12]    = interval_timer0_event_in;
        src_event[16:13] = timer_array_event_in;
        src_event[17]    = comparator0_event_in;
        src_event[18]    = comparator1_event_in;
    end

    // each pulse reaches only the destination its select names
    always_comb
    begin
        dest_hit = '0;
        for (int s = 0; s < EVR_NUM_SRC; s++)
        begin
            if (src_event[s])
            begin
                dest_hit = dest_hit | evr_dest_onehot(route_sel[s]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // direct paths: adc trigger and interval timer count source

    logic next_adc;
    logic next_it0;

    always_comb
    begin
        next_adc = dest_hit[EVR_D_ADC];
        next_it0 = dest_hit[EVR_D_IT0];
    end

    always_ff @(posedge clk_in)
    begin
        adc_start_out             <= rst_in ? 1'b0 : next_adc;
        interval_timer0_count_out <= rst_in ? 1'b0 : next_it0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // delayed paths: timer array edge detect and capture timer response

    logic [1:0] ta_q;
    logic [1:0] ct_q;

    evr_delay_line #(
        .DEPTH (EVR_TA_LAT_CYC),
        .WIDTH (2)
    ) u_ta_delay (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (dest_hit[EVR_D_TA1:EVR_D_TA0]),
        .q_out  (ta_q)
    );

    evr_delay_line #(
        .DEPTH (EVR_CT_LAT_CYC),
        .WIDTH (2)
    ) u_ct_delay (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (dest_hit[EVR_D_CT1:EVR_D_CT0]),
        .q_out  (ct_q)
    );

    // outputs are the delay lines' last flops; capture and cutoff share an event
    always_comb
    begin
        timer_array_ch0_in_out     = ta_q[0];
        timer_array_ch1_in_out     = ta_q[1];
        capture_timer0_d_input_out = ct_q[0];
        capture_timer0_cutoff_out  = ct_q[0];
        capture_timer1_d_input_out = ct_q[1];
        capture_timer1_cutoff_out  = ct_q[1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    adc_route_a : assert property (@(posedge clk_in) disable iff (rst_in)
        dest_hit[EVR_D_ADC] |=> adc_start_out)
        else $error("adc trigger missing one cycle after routed event");

    it0_route_a : assert property (@(posedge clk_in) disable iff (rst_in)
        !dest_hit[EVR_D_IT0] |=> !interval_timer0_count_out)
        else $error("interval timer count without routed event");

    ta_latency_a : assert property (@(posedge clk_in) disable iff (rst_in)
        dest_hit[EVR_D_TA0] |-> ##3 timer_array_ch0_in_out)
        else $error("timer array channel 0 input not three cycles later");

    ta_quiet_a : assert property (@(posedge clk_in) disable iff (rst_in)
        !dest_hit[EVR_D_TA1] ##1 !dest_hit[EVR_D_TA1] ##1 !dest_hit[EVR_D_TA1]
        |=> !timer_array_ch1_in_out)
        else $error("timer array channel 1 input without routed event");

    ct_latency_a : assert property (@(posedge clk_in) disable iff (rst_in)
        dest_hit[EVR_D_CT1] |-> ##2 (capture_timer1_cutoff_out && capture_timer1_d_input_out))
        else $error("capture timer 1 cutoff not two cycles later");

    all_off_a : assert property (@(posedge clk_in) disable iff (rst_in)
        (route_sel[0] == EVR_SEL_OFF && src_event == 19'h00001) |=> !adc_start_out
        && !interval_timer0_count_out)
        else $error("disabled source forwarded an event");

    sel_write_a : assert property (@(posedge clk_in) disable iff (rst_in)
        (wr_en && wr_idx == 5'h07) |=> route_sel[7] == $past(hwdata_in[2:0]))
        else $error("select register 07 did not take the written code");

    read_upper_a : assert property (@(posedge clk_in) disable iff (rst_in)
        (rd_en && rd_idx < 5'h13) |=> (hrdata_out[31:3] == 29'h0000_0000))
        else $error("select register read shows upper bits set");

    key_absent_a : assert property (@(posedge clk_in) disable iff (rst_in)
        !HAS_KEY_RETURN |-> route_sel[EVR_SRC_KEY] == EVR_SEL_OFF)
        else $error("key return select live in variant without it");

    reset_zero_a : assert property (@(posedge clk_in)
        rst_in |=> (route_sel[18] == 3'h0 && route_sel[0] == 3'h0 && !adc_start_out))
        else $error("select registers not zero after reset");

    prohib_flag_a : assert property (@(posedge clk_in) disable iff (rst_in)
        (route_sel[3] == EVR_SEL_BAD && src_event[3]) |=> (status[6] && !adc_start_out))
        else $error("prohibited code not flagged or forwarded an event");

    // second channel and capture timer 0 get the same latency checks
    ct0_latency_a : assert property (@(posedge clk_in) disable iff (rst_in)
        dest_hit[EVR_D_CT0] |-> ##2 (capture_timer0_cutoff_out && capture_timer0_d_input_out))
        else $error("capture timer 0 cutoff not two cycles later");

    ta1_latency_a : assert property (@(posedge clk_in) disable iff (rst_in)
        dest_hit[EVR_D_TA1] |-> ##3 timer_array_ch1_in_out)
        else $error("timer array channel 1 input not three cycles later");

    it0_count_a : assert property (@(posedge clk_in) disable iff (rst_in)
        dest_hit[EVR_D_IT0] |=> interval_timer0_count_out)
        else $error("interval timer count missing one cycle after routed event");

    // quiet destinations must stay quiet, not only fire when asked
    adc_quiet_a : assert property (@(posedge clk_in) disable iff (rst_in)
        !dest_hit[EVR_D_ADC] |=> !adc_start_out)
        else $error("adc trigger without routed event");

    ct_quiet_a : assert property (@(posedge clk_in) disable iff (rst_in)
        !dest_hit[EVR_D_CT0] ##1 !dest_hit[EVR_D_CT0] |=> !capture_timer0_cutoff_out)
        else $error("capture timer 0 cutoff without routed event");

    status_bad_a : assert property (@(posedge clk_in) disable iff (rst_in)
        (route_sel[18] == EVR_SEL_BAD) |-> status[6])
        else $error("prohibited code in select 18 not flagged");

    bus_okay_a : assert property (@(posedge clk_in) disable iff (rst_in)
        1'b1 |-> (hreadyout_out && !hresp_out))
        else $error("register bus stalled or answered with an error");

endmodule : evr_router

/* verilog/evr_pkg.sv */
/*
 * evr_pkg: constants, select codes and decode helper for the event router.
 * assumes: one system clock, word-wide ahb-lite register access.
 */
package evr_pkg;

    localparam int EVR_NUM_SRC  = 19;   // event sources
    localparam int EVR_NUM_DEST = 6;    // receiving operations
    localparam int EVR_SEL_W    = 3;    // live select bits
    localparam int EVR_IDX_W    = 5;    // local register index width

    // printed offsets are register indices, byte address is four times that
    localparam logic [29:0] EVR_IDX_FIRST  = 30'h000f0300;
    localparam logic [29:0] EVR_IDX_LAST   = 30'h000f0312;
    localparam logic [29:0] EVR_IDX_STATUS = 30'h000f0313;
    localparam logic [4:0]  EVR_LOC_STATUS = 5'h13;
    localparam logic [7:0]  EVR_SEL_RESET  = 8'h00;
    localparam int          EVR_SRC_KEY    = 6;     // key-return source

    // select codes
    localparam logic [2:0] EVR_SEL_OFF  = 3'h0;
    localparam logic [2:0] EVR_SEL_ADC  = 3'h1;
    localparam logic [2:0] EVR_SEL_TA0  = 3'h2;
    localparam logic [2:0] EVR_SEL_TA1  = 3'h3;
    localparam logic [2:0] EVR_SEL_IT0  = 3'h4;
    localparam logic [2:0] EVR_SEL_CT0  = 3'h5;
    localparam logic [2:0] EVR_SEL_CT1  = 3'h6;
    localparam logic [2:0] EVR_SEL_BAD  = 3'h7;

    // destination bit positions
    localparam int EVR_D_ADC = 0;
    localparam int EVR_D_TA0 = 1;
    localparam int EVR_D_TA1 = 2;
    localparam int EVR_D_IT0 = 3;
    localparam int EVR_D_CT0 = 4;
    localparam int EVR_D_CT1 = 5;

    // latencies in system clock cycles, source pulse to output
    localparam int EVR_DIRECT_LAT_CYC = 1;
    localparam int EVR_TA_LAT_CYC     = 3;
    localparam int EVR_CT_LAT_CYC     = 2;

    // ahb-lite encodings
    localparam logic [1:0] EVR_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] EVR_HTRANS_SEQ    = 2'h3;
    localparam logic [2:0] EVR_HSIZE_WORD    = 3'h2;

    typedef logic [EVR_SEL_W-1:0] evr_sel_t;

    // one-hot destination for a select code; off and prohibited give none
    function automatic logic [EVR_NUM_DEST-1:0] evr_dest_onehot(input evr_sel_t sel);
        logic [EVR_NUM_DEST-1:0] hot;
        hot = '0;
        if (sel != EVR_SEL_OFF && sel != EVR_SEL_BAD)
        begin
            hot[sel - 3'h1] = 1'b1;
        end
        return hot;
    endfunction : evr_dest_onehot

endpackage : evr_pkg

/* verilog/evr_delay_line.sv */
/*
 * evr_delay_line: fixed pulse delay of DEPTH clock cycles.
 * assumes: input is a same-clock pulse vector.
 */
`timescale 1ns/1ps
module evr_delay_line
    import evr_pkg::*;
#(
    parameter int DEPTH = 2,
    parameter int WIDTH = 1
)(
    input  wire logic             clk_in,   // system clock
    input  wire logic             rst_in,   // sync reset, high
    input  wire logic [WIDTH-1:0] d_in,     // pulses in
    output logic      [WIDTH-1:0] q_out     // pulses DEPTH cycles later
);

    initial
    begin
        if (DEPTH < 1 || WIDTH < 1)
        begin
            $error("evr_delay_line: DEPTH and WIDTH must be at least 1");
        end
    end

    logic [WIDTH-1:0] stage      [DEPTH];
    logic [WIDTH-1:0] next_stage [DEPTH];

    // shift one stage per cycle
    always_comb
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            next_stage[i] = (i == 0) ? d_in : stage[(i == 0) ? 0 : i - 1];
        end
    end

    always_ff @(posedge clk_in)
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            stage[i] <= rst_in ? '0 : next_stage[i];
        end
    end

    assign q_out = stage[DEPTH-1];

endmodule : evr_delay_line

/* verilog/evr_ahb_slave.sv */
/*
 * evr_ahb_slave: ahb-lite address decode for the router registers.
 * assumes: single word transfers; slave never inserts wait states.
 */
`timescale 1ns/1ps
module evr_ahb_slave
    import evr_pkg::*;
(
    input  wire logic                 clk_in,     // system clock
    input  wire logic                 rst_in,     // sync reset, high
    input  wire logic                 hsel_in,    // slave select
    input  wire logic [31:0]          haddr_in,   // byte address
    input  wire logic [1:0]           htrans_in,  // transfer type
    input  wire logic                 hwrite_in,  // write when high
    input  wire logic [2:0]           hsize_in,   // transfer size
    input  wire logic                 hready_in,  // bus ready
    output logic                      rd_en_out,  // address-phase read hit
    output logic [EVR_IDX_W-1:0]      rd_idx_out, // read register index
    output logic                      wr_en_out,  // data-phase write hit
    output logic [EVR_IDX_W-1:0]      wr_idx_out  // write register index
);

    logic [29:0]          offset;
    logic                 hit;
    logic                 next_wr_en;
    logic [EVR_IDX_W-1:0] next_wr_idx;

    // decode: word size, aligned, inside the register window
    always_comb
    begin
        offset = haddr_in[31:2] - EVR_IDX_FIRST;
        hit    = hsel_in && hready_in && htrans_in[1] && (hsize_in == EVR_HSIZE_WORD)
                 && (haddr_in[1:0] == 2'h0) && (haddr_in[31:2] >= EVR_IDX_FIRST)
                 && (haddr_in[31:2] <= EVR_IDX_STATUS);
        rd_en_out   = hit && !hwrite_in;
        rd_idx_out  = offset[EVR_IDX_W-1:0];
        next_wr_en  = hit && hwrite_in;
        next_wr_idx = offset[EVR_IDX_W-1:0];
    end

    // writes complete in the data phase, when hwdata is valid
    always_ff @(posedge clk_in)
    begin
        wr_en_out  <= rst_in ? 1'b0 : next_wr_en;
        wr_idx_out <= rst_in ? '0 : next_wr_idx;
    end

endmodule : evr_ahb_slave

/* sim/evr_periph_model.sv */
/*
 * evr_periph_model: the event-producing peripherals around the router.
 * assumes: bench raises fire_in for one clk_in cycle per event.
 */
`timescale 1ns/1ps
module evr_periph_model
    import evr_pkg::*;
(
    input  wire logic       fire_in,       // one event this cycle
    input  wire logic [4:0] src_idx_in,    // which source fires
    output logic [5:0]      ext_edge_out,  // sources 0-5
    output logic            key_out,       // source 6
    output logic [3:0]      ct_ab_out,     // sources 7-10
    output logic            ct1_under_out, // source 11
    output logic            it0_under_out, // source 12
    output logic [3:0]      ta_end_out,    // sources 13-16
    output logic [1:0]      cmp_out        // sources 17-18
);
    logic [18:0] src;

    ////////////////////////////////////////////////////////////////////////////////
    // one pulse on one source; idle lines rest low, so no stale level lingers
    assign src           = fire_in ? (19'h00001 << src_idx_in) : 19'h00000;
    assign ext_edge_out  = src[5:0];
    assign key_out       = src[6];
    assign ct_ab_out     = src[10:7];
    assign ct1_under_out = src[11];
    assign it0_under_out = src[12];
    assign ta_end_out    = src[16:13];
    assign cmp_out       = src[18:17];
endmodule : evr_periph_model

/* sim/tb_top.sv */
/*
 * tb_top: self-checking bench for the event router.
 * assumes: zero-wait slave, single word transfers, one clock.
 */
`timescale 1ns/1ps
module tb_top;
    import evr_pkg::*;
    logic        clk_in, rst_in, hsel, hwrite, hready, hresp, fire;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, cmp;
    logic [2:0]  hsize;
    logic [4:0]  src_idx;
    logic [5:0]  ext;
    logic [3:0]  ct_ab, ta_end;
    logic        key, ct1_under, it0_under;
    logic [7:0]  outs;
    int          n_fail;
    int          num_checks;

    ////////////////////////////////////////////////////////////////////////////////
    // clock
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // partner and design; hready loops back as the only slave
    evr_periph_model i_evr_periph_model (.fire_in(fire), .src_idx_in(src_idx),
        .ext_edge_out(ext), .key_out(key), .ct_ab_out(ct_ab), .ct1_under_out(ct1_under),
        .it0_under_out(it0_under), .ta_end_out(ta_end), .cmp_out(cmp));
    evr_router i_evr_router (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .ext_edge_event_in(ext),
        .key_return_event_in(key), .capture_timer0_event_a_in(ct_ab[0]),
        .capture_timer0_event_b_in(ct_ab[1]), .capture_timer1_event_a_in(ct_ab[2]),
        .capture_timer1_event_b_in(ct_ab[3]), .capture_timer1_under_in(ct1_under),
        .interval_timer0_event_in(it0_under), .timer_array_event_in(ta_end),
        .comparator0_event_in(cmp[0]), .comparator1_event_in(cmp[1]),
        .adc_start_out(outs[0]), .timer_array_ch0_in_out(outs[1]),
        .timer_array_ch1_in_out(outs[2]), .interval_timer0_count_out(outs[3]),
        .capture_timer0_d_input_out(outs[4]), .capture_timer0_cutoff_out(outs[5]),
        .capture_timer1_d_input_out(outs[6]), .capture_timer1_cutoff_out(outs[7]));

    ////////////////////////////////////////////////////////////////////////////////
    // verdict, compare and bus helpers
    task automatic conclude();
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // bounded wait for hready high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1)
        begin
            n_fail++;
            conclude();
        end
    endtask : wait_ready

    task automatic ahb(input bit wr, input logic [29:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_in);
        hsel   <= 1'b1;
        htrans <= EVR_HTRANS_NONSEQ;
        haddr  <= {idx, 2'b00};
        hwrite <= wr;
        hsize  <= EVR_HSIZE_WORD;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : ahb

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic reg_defaults();
        logic [31:0] rd;
        for (int r = 0; r < EVR_NUM_SRC; r++)
        begin
            ahb(1'b0, EVR_IDX_FIRST + 30'(r), 32'h0, rd);
            check("select after reset", 32'h0, rd);
        end
        ahb(1'b0, EVR_IDX_FIRST - 30'h1, 32'h0, rd);
        check("unmapped read", 32'h0, rd);
        check("hresp", 32'h0, {31'h0, hresp});
    endtask : reg_defaults

    // upper bits never stick, low three bits store whatever is written
    task automatic reg_fields();
        logic [31:0] rd;
        ahb(1'b1, EVR_IDX_LAST, 32'hffffffff, rd);
        ahb(1'b0, EVR_IDX_LAST, 32'h0, rd);
        check("select all ones", 32'h7, rd);
        ahb(1'b0, EVR_IDX_STATUS, 32'h0, rd);
        check("status prohibited", 32'h40, rd);
        ahb(1'b1, EVR_IDX_LAST, 32'h000000fa, rd);
        ahb(1'b0, EVR_IDX_LAST, 32'h0, rd);
        check("select upper bits", 32'h2, rd);
        ahb(1'b1, EVR_IDX_LAST, 32'h0, rd);
        ahb(1'b0, EVR_IDX_STATUS, 32'h0, rd);
        check("status clear", 32'h0, rd);
    endtask : reg_fields

    function automatic logic [7:0] exp_outs(input logic [2:0] code, input int c);
        case (code)
            3'h1: return (c == 1) ? 8'h01 : 8'h00;
            3'h2: return (c == 3) ? 8'h02 : 8'h00;
            3'h3: return (c == 3) ? 8'h04 : 8'h00;
            3'h4: return (c == 1) ? 8'h08 : 8'h00;
            3'h5: return (c == 2) ? 8'h30 : 8'h00;
            3'h6: return (c == 2) ? 8'hc0 : 8'h00;
            default: return 8'h00;
        endcase
    endfunction : exp_outs

    // route one source, fire it while idle otherwise, watch five cycles, unroute
    task automatic route_case(input int s, input logic [2:0] code);
        logic [31:0] rd;
        ahb(1'b1, EVR_IDX_FIRST + 30'(s), {29'h0, code}, rd);
        @(posedge clk_in);
        fire    <= 1'b1;
        src_idx <= 5'(s);
        @(posedge clk_in);
        fire <= 1'b0;
        for (int c = 1; c <= 5; c++)
        begin
            if (c > 1)
                @(posedge clk_in);
            #1;
            check("routed outputs", {24'h0, exp_outs(code, c)}, {24'h0, outs});
        end
        ahb(1'b1, EVR_IDX_FIRST + 30'(s), 32'h0, rd);
    endtask : route_case

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence; each source meets one code in turn, one route at a time
    initial
    begin
        n_fail = 0;
        num_checks = 0;
        rst_in = 1'b1;
        {hsel, hwrite, fire} = 3'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h0;
        src_idx = 5'h0;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        reg_defaults();
        reg_fields();
        for (int s = 0; s < EVR_NUM_SRC; s++)
            route_case(s, 3'(((s + 4) % 6) + 1));
        route_case(0, EVR_SEL_OFF);
        route_case(3, EVR_SEL_BAD);
        conclude();
    end
endmodule : tb_top
